// *** test/apst_drive_model.sv ***
`timescale 1ns/1ps
// drive side: counts the steps it receives per axis, echoes its hold state
module apst_drive_model (
  input wire logic clk_i,
  input wire logic zero_i,
  input wire logic pdir_i,
  input wire logic [apst_pkg::NUM_AXES-1:0] step_a_i,
  input wire logic [apst_pkg::NUM_AXES-1:0] step_b_i,
  input wire logic [apst_pkg::NUM_AXES-1:0] hold_i,
  output logic [apst_pkg::NUM_AXES-1:0] fb_o,
  output logic [apst_pkg::NUM_AXES-1:0][apst_pkg::CNT_W-1:0] seen_o
);
  import apst_pkg::*;
  logic [NUM_AXES-1:0] a_q, b_q; // pin levels one edge back
  // count received steps
  // in pulse+direction mode the second pin is a level, so it never counts
  always_ff @(posedge clk_i) begin
    a_q <= step_a_i;
    b_q <= step_b_i;
    for (int i = 0; i < NUM_AXES; i++) begin
      if (zero_i) begin
        seen_o[i] <= '0;
      end else if ((step_a_i[i] && !a_q[i]) || (!pdir_i && step_b_i[i] && !b_q[i])) begin
        seen_o[i] <= seen_o[i] + 1'b1;
      end
    end
  end
  // drive reports itself held while the hold-off line is high
  assign fb_o = hold_i;
endmodule

// *** test/tb_axis_pulse_output_and_stop_timing.sv ***
`timescale 1ns/1ps
module tb_axis_pulse_output_and_stop_timing;
  import apst_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, cmd_v = 1'b0, pdm = 1'b1, mwe = 1'b0, zr = 1'b1;
  logic mcint = 1'b1, clr = 1'b0, srd = 1'b0, emergency_stop_input = 1'b1, emgsel = 1'b0; // emg 1: loop open
  apst_cmd_s cmd = '0;
  apst_mode_wr_s mw = '0;
  logic [NUM_AXES-1:0] eis = '0, eie = '0, eds = '0, ede = '0, aux = '0, exp_h = '0, exp_r = '0;
  logic [NUM_AXES-1:0] fb, pa, pb, hold, res, busy;
  logic [NUM_AXES-1:0][CNT_W-1:0] pcnt, seen;
  apst_in_stat_s stat;
  logic irq, rdy;
  logic [CNT_W-1:0] s0, s1;
  int error_cnt = 0;
  int checks = 0;
  always #4 clk = ~clk;
  // short qualifier so external stops act within a few cycles
  apst_top #(.EXT_FILT_CYC(8)) u_apst_top (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1),
    .CMD_VALID_I(cmd_v), .CMD_I(cmd), .PULSE_DIR_MODE_I(pdm), .AXIS_MODE_WR_EN_I(mwe),
    .AXIS_MODE_WRITE_REG3_I(mw), .EXT_INST_STOP_I(eis), .EXT_INST_EN_I(eie),
    .EXT_DECEL_STOP_I(eds), .EXT_DECEL_EN_I(ede), .EMERGENCY_STOP_INPUT_I(emergency_stop_input),
    .EMERGENCY_OPEN_SEL_I(emgsel), .AUX_INPUT_ZERO_PAIR_I(aux), .DRIVE_FEEDBACK_I(fb),
    .MC_INT_N_I(mcint), .IRQ_CLEAR_I(clr), .STATUS_READ_I(srd), .DRIVE_PULSE_OUTPUTS_O(pa),
    .DIRECTION_PULSE_OUTPUT_O(pb), .HOLD_OFF_GENERAL_OUTPUT_O(hold),
    .STEP_RESOLUTION_GENERAL_OUTPUT_O(res), .BUSY_O(busy), .PULSE_CNT_O(pcnt),
    .INPUT_STATUS_READ_REGS_O(stat), .HOST_IRQ_O(irq), .HOST_READY_O(rdy));
  apst_drive_model u_apst_drive_model (.clk_i(clk), .zero_i(zr), .pdir_i(pdm), .step_a_i(pa),
    .step_b_i(pb), .hold_i(hold), .fb_o(fb), .seen_o(seen));
  // a mode write changes only the selected axes
  function automatic logic [3:0] upd(input logic [3:0] old, input logic [3:0] ax, input logic b);
    return (old & ~ax) | (ax & {4{b}});
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // inputs only ever move at the falling edge
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic go(input apst_cmd_e c, input logic [3:0] ax, input logic [31:0] cnt,
                    input logic [3:0] dr = 4'hf);
    cmd = '{axes: ax, code: c, dirs: dr, count: cnt, period: 16'h0006};
    cmd_v = 1'b1;
    cyc(1);
    cmd_v = 1'b0;
  endtask
  task automatic fresh();
    zr = 1'b1;
    cyc(1);
    zr = 1'b0;
  endtask
  // bounded wait for every axis to go idle
  task automatic idle(input int lim);
    for (int n = 0; busy !== 4'h0; n++) begin
      if (n >= lim) begin
        error_cnt++;
        report_and_stop();
      end
      cyc(1);
    end
  endtask
  task automatic cnt_match(input logic [3:0] m);
    for (int i = 0; i < NUM_AXES; i++) begin
      if (m[i]) chk("pulse_cnt", seen[i], pcnt[i]);
    end
  endtask
  task automatic report_and_stop();
    if (error_cnt == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(32'h32ff5ccd));
    cyc(16);
    rst_n = 1'b1;
    zr = 1'b0;
    cyc(62);
    chk("ready_early", 0, rdy);
    chk("pins_after_reset", 0, {pa, pb, hold, res, busy, irq});
    cyc(1);
    chk("ready", 1, rdy);
    // random mode writes, the first one a hand-picked all-axes set
    for (int i = 0; i < 6; i++) begin
      mw = (i == 0) ? apst_mode_wr_s'{4'hf, 16'h0300} : apst_mode_wr_s'($urandom);
      aux = 4'($urandom);
      exp_h = upd(exp_h, mw.axes, mw.data[HOLD_OUTPUT_BIT_POS]);
      exp_r = upd(exp_r, mw.axes, mw.data[RESOLUTION_OUTPUT_BIT_POS]);
      mwe = 1'b1;
      cyc(1);
      mwe = 1'b0;
      cyc(2);
      chk("hold_out", exp_h, hold);
      chk("res_out", exp_r, res);
      chk("in_status", {aux, exp_h}, stat);
      cyc(23);
    end
    // two axes start together; one is stopped, the other runs its count out
    s0 = 32'($urandom_range(6, 3));
    go(CMD_DRIVE, 4'b0011, s0);
    cyc(32);
    chk("dir_early", 0, pb[0]);
    cyc(1);
    chk("dir_valid", 1, pb[0]);
    cyc(45);
    chk("pulse_early", 0, pa[0]);
    cyc(1);
    chk("first_pulse", 1, pa[0]);
    go(CMD_STOP, 4'b0010, 0);
    idle(200);
    chk("stop_cnt", 1, seen[1] <= 2);
    chk("full_cnt", s0, seen[0]);
    cnt_match(4'b0011);
    // deceleration command in the two-pulse mode
    pdm = 1'b0;
    fresh();
    go(CMD_DRIVE, 4'b0001, 100);
    cyc(100);
    s0 = seen[0] + 32'(pb[0]);
    go(CMD_DECEL, 4'b0001, 0);
    idle(40);
    chk("decel_cnt", 1, seen[0] <= s0 + 2);
    cnt_match(4'b0001);
    // external instant stop on axis 2, external decel on axis 3
    fresh();
    eie = 4'b0100;
    ede = 4'b1000;
    go(CMD_DRIVE, 4'b1100, 1000);
    cyc(100);
    s0 = seen[2] + 32'(pb[2]);
    s1 = seen[3] + 32'(pb[3]);
    eis = 4'b0100;
    eds = 4'b1000;
    idle(60);
    chk("ext_inst", 1, seen[2] <= s0 + 3);
    chk("ext_decel", 1, seen[3] <= s1 + 4);
    cnt_match(4'b1100);
    eis = '0;
    eds = '0;
    // emergency polarity: open loop with alternate jumper, then shorted
    cyc(20);
    emgsel = 1'b1;
    go(CMD_DRIVE, 4'b0001, 10);
    cyc(20);
    chk("emg_open", 0, busy[0]);
    emgsel = 1'b0;
    emergency_stop_input = 1'b0;
    cyc(20);
    go(CMD_DRIVE, 4'b0001, 10);
    cyc(20);
    chk("emg_short", 0, busy[0]);
    emergency_stop_input = 1'b1;
    cyc(20);
    // interpolation start: direction settles just ahead of the first pulse
    pdm = 1'b1;
    go(CMD_INTERP, 4'b1000, 1, 4'h0);
    chk("emg_released", 1, busy[3]);
    cyc(80);
    chk("interp_dir_old", 1, pb[3]);
    cyc(14);
    chk("interp_early", 0, pa[3]);
    chk("interp_dir", 0, pb[3]);
    cyc(1);
    chk("interp_pulse", 1, pa[3]);
    idle(40);
    // interrupt latch: set, hold, clear, disarmed, rearmed by status read
    mcint = 1'b0;
    cyc(2);
    chk("irq_set", 1, irq);
    mcint = 1'b1;
    cyc(2);
    chk("irq_held", 1, irq);
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    cyc(1);
    chk("irq_clear", 0, irq);
    mcint = 1'b0;
    cyc(2);
    chk("irq_disarmed", 0, irq);
    mcint = 1'b1;
    srd = 1'b1;
    cyc(1);
    srd = 1'b0;
    mcint = 1'b0;
    cyc(2);
    chk("irq_rearmed", 1, irq);
    report_and_stop();
  end
endmodule

// *** verilog/apst_filt.sv ***
`timescale 1ns/1ps
// level qualifier: a change passes only after holding for CYC cycles
module apst_filt #(
  parameter int CYC = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic raw_i,
  output logic lvl_o
);
  localparam int W = $clog2(CYC + 1);

  typedef struct packed {
    logic lvl;
    logic [W-1:0] cnt;
  } apst_filt_s;

  apst_filt_s q_reg;
  apst_filt_s q_next;

  // count how long the input has differed from the accepted level
  always_comb begin
    q_next = q_reg;
    if (raw_i == q_reg.lvl) begin
      q_next.cnt = '0;
    end else if (q_reg.cnt == W'(CYC - 1)) begin
      q_next.lvl = raw_i;
      q_next.cnt = '0;
    end else begin
      q_next.cnt = q_reg.cnt + W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_reg <= '0;
    end else if (ce_i) begin
      q_reg <= q_next;
    end
  end

  assign lvl_o = q_reg.lvl;
endmodule

// *** verilog/apst_irq_latch.sv ***
`timescale 1ns/1ps
// inverting interrupt latch between controller and host bus
module apst_irq_latch (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic int_n_i,
  input wire logic clr_i,
  input wire logic status_rd_i,
  output logic irq_o
);
  typedef struct packed {
    logic int_n_d; // previous interrupt level
    logic irq; // latched host request
    logic armed; // a new fall may set the latch
    logic rd_seen; // status read seen since last set
  } apst_irq_s;

  apst_irq_s q_reg;
  apst_irq_s q_next;
  logic fell;
  logic set;

  assign fell = q_reg.int_n_d & ~int_n_i;
  assign set = fell & q_reg.armed;

  // set wins over a same-cycle clear so no event is lost
  always_comb begin
    q_next = q_reg;
    q_next.int_n_d = int_n_i;
    q_next.irq = set | (q_reg.irq & ~clr_i);
    if (set) begin
      q_next.armed = 1'b0;
      q_next.rd_seen = 1'b0;
    end else if (!q_reg.armed) begin
      if (status_rd_i) begin
        q_next.rd_seen = 1'b1;
      end
      if ((q_reg.rd_seen || status_rd_i) && int_n_i) begin
        q_next.armed = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_reg <= '{int_n_d: 1'b1, irq: 1'b0, armed: 1'b1, rd_seen: 1'b0};
    end else if (ce_i) begin
      q_reg <= q_next;
    end
  end

  assign irq_o = q_reg.irq;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_irq_latch_set: assert property (ce_i && fell && q_reg.armed |=> irq_o)
    else $error("controller interrupt fall not latched");
  a_irq_held_clear: assert property (ce_i && irq_o && !clr_i |=> irq_o)
    else $error("host interrupt dropped without clear");
endmodule

// *** verilog/apst_pkg.sv ***
// Summary of operation
// - invert and latch falling controller interrupt
// - hold-off output follows hold bit
// - resolution output follows resolution bit
// - aux zero and feedback inputs readable
// - outputs defined within 250 ns of reset
// - single-axis first pulse within 650 ns
// - direction at 275 ns, pulse 375 later
// - interpolation first pulse within 775 ns
// - interpolation direction changes near pulse high
// - external instant stop: 400 us plus one
// - stop command: at most one pulse
// - external decel stop: 400 us plus two
// - decel command: at most two pulses
// - emergency polarity selects shorted or open
package apst_pkg;

  // geometry
  localparam int NUM_AXES = 4;
  localparam int CNT_W = 32; // pulse counts
  localparam int PER_W = 16; // pulse period in cycles
  localparam int LEAD_W = 8; // start latency counter
  localparam int WAIT_W = 7; // host access wait counter

  // clock and documented times
  localparam int CLK_PERIOD_NS = 8;
  localparam int HOST_WAIT_NS = 500;
  localparam int FIRST_PULSE_NS = 650;
  localparam int DIR_VALID_NS = 275;
  localparam int DIR_TO_PULSE_NS = 375;
  localparam int INTERP_PULSE_NS = 775;
  localparam int INTERP_DIR_WIN_NS = 125;
  localparam int EXT_STOP_US = 400;

  // latencies are upper bounds, so they round down
  localparam logic [LEAD_W-1:0] FIRST_PULSE_CYC = LEAD_W'(FIRST_PULSE_NS / CLK_PERIOD_NS);
  localparam logic [LEAD_W-1:0] DIR_VALID_CYC = LEAD_W'(DIR_VALID_NS / CLK_PERIOD_NS);
  localparam logic [LEAD_W-1:0] DIR_TO_PULSE_CYC = LEAD_W'(DIR_TO_PULSE_NS / CLK_PERIOD_NS);
  localparam logic [LEAD_W-1:0] DIR_PULSE_CYC = LEAD_W'(DIR_VALID_CYC + DIR_TO_PULSE_CYC);
  localparam logic [LEAD_W-1:0] INTERP_PULSE_CYC = LEAD_W'(INTERP_PULSE_NS / CLK_PERIOD_NS);
  localparam int INTERP_DIR_WIN_CYC = INTERP_DIR_WIN_NS / CLK_PERIOD_NS;
  // the host wait is a least time, so it rounds up
  localparam logic [WAIT_W-1:0] HOST_WAIT_CYC =
    WAIT_W'((HOST_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // external stop qualification window
  localparam int EXT_FILT_CYC = EXT_STOP_US * 1000 / CLK_PERIOD_NS;

  // mode register field positions
  localparam int HOLD_OUTPUT_BIT_POS = 8;
  localparam int RESOLUTION_OUTPUT_BIT_POS = 9;

  // shortest legal pulse period and decel pulse allowance
  localparam logic [PER_W-1:0] PERIOD_MIN = 16'h0002;
  localparam logic [CNT_W-1:0] DECEL_LEFT = 32'h0000_0002;

  // axis sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LEAD = 3'b010,
    ST_RUN  = 3'b100
  } apst_state_e;

  // host commands
  typedef enum logic [3:0] {
    CMD_DRIVE  = 4'b0001,
    CMD_INTERP = 4'b0010,
    CMD_STOP   = 4'b0100,
    CMD_DECEL  = 4'b1000
  } apst_cmd_e;

  typedef struct packed {
    logic [NUM_AXES-1:0] axes;
    apst_cmd_e code;
    logic [NUM_AXES-1:0] dirs;
    logic [CNT_W-1:0] count;
    logic [PER_W-1:0] period;
  } apst_cmd_s;

  typedef struct packed {
    logic [NUM_AXES-1:0] axes;
    logic [15:0] data;
  } apst_mode_wr_s;

  typedef struct packed {
    logic [NUM_AXES-1:0] aux_zero;
    logic [NUM_AXES-1:0] drv_fb;
  } apst_in_stat_s;

  typedef struct packed {
    apst_state_e state;
    logic pdir;
    logic interp;
    logic dir_pend;
    logic dir_out;
    logic pulse;
    logic p_out;
    logic m_out;
    logic hold_out;
    logic res_out;
    logic [LEAD_W-1:0] tgt;
    logic [LEAD_W-1:0] dtgt;
    logic [LEAD_W-1:0] elapsed;
    logic [PER_W-1:0] ph;
    logic [PER_W-1:0] half;
    logic [PER_W-1:0] period;
    logic [CNT_W-1:0] remain;
    logic [CNT_W-1:0] emitted;
  } apst_axis_s;

  typedef struct packed {
    apst_axis_s [NUM_AXES-1:0] ax;
    logic [WAIT_W-1:0] wait_cnt;
    logic ready;
    apst_in_stat_s stat;
  } apst_top_s;

  localparam apst_axis_s AXIS_RST = '{state: ST_IDLE, default: '0};
  localparam apst_top_s TOP_RST = '{ax: '{default: AXIS_RST}, wait_cnt: '0, ready: 1'b0,
                                    stat: '0};

endpackage

// *** verilog/apst_top.sv ***
`timescale 1ns/1ps
// four-axis pulse output sequencer with stop timing and host interrupt latch
module apst_top #(
  parameter int EXT_FILT_CYC = apst_pkg::EXT_FILT_CYC
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire logic CMD_VALID_I,
  input apst_pkg::apst_cmd_s CMD_I,
  input wire logic PULSE_DIR_MODE_I,
  input wire logic AXIS_MODE_WR_EN_I,
  input apst_pkg::apst_mode_wr_s AXIS_MODE_WRITE_REG3_I,
  input wire logic [apst_pkg::NUM_AXES-1:0] EXT_INST_STOP_I,
  input wire logic [apst_pkg::NUM_AXES-1:0] EXT_INST_EN_I,
  input wire logic [apst_pkg::NUM_AXES-1:0] EXT_DECEL_STOP_I,
  input wire logic [apst_pkg::NUM_AXES-1:0] EXT_DECEL_EN_I,
  input wire logic EMERGENCY_STOP_INPUT_I,
  input wire logic EMERGENCY_OPEN_SEL_I,
  input wire logic [apst_pkg::NUM_AXES-1:0] AUX_INPUT_ZERO_PAIR_I,
  input wire logic [apst_pkg::NUM_AXES-1:0] DRIVE_FEEDBACK_I,
  input wire logic MC_INT_N_I,
  input wire logic IRQ_CLEAR_I,
  input wire logic STATUS_READ_I,
  output logic [apst_pkg::NUM_AXES-1:0] DRIVE_PULSE_OUTPUTS_O,
  output logic [apst_pkg::NUM_AXES-1:0] DIRECTION_PULSE_OUTPUT_O,
  output logic [apst_pkg::NUM_AXES-1:0] HOLD_OFF_GENERAL_OUTPUT_O,
  output logic [apst_pkg::NUM_AXES-1:0] STEP_RESOLUTION_GENERAL_OUTPUT_O,
  output logic [apst_pkg::NUM_AXES-1:0] BUSY_O,
  output logic [apst_pkg::NUM_AXES-1:0][apst_pkg::CNT_W-1:0] PULSE_CNT_O,
  output apst_pkg::apst_in_stat_s INPUT_STATUS_READ_REGS_O,
  output logic HOST_IRQ_O,
  output logic HOST_READY_O
);
  import apst_pkg::*;

  // window for the interpolation direction check
  localparam int DIR_WIN = INTERP_DIR_WIN_CYC;

  apst_top_s q_reg; // whole block state
  apst_top_s q_next; // next value of the whole block state
  logic emg_act; // emergency stop asserted after jumper polarity
  logic [NUM_AXES-1:0] ext_inst_f; // qualified external instant stop
  logic [NUM_AXES-1:0] ext_decel_f; // qualified external decel stop
  logic [NUM_AXES-1:0] cmd_hit; // command addressed to this axis
  logic [NUM_AXES-1:0] inst_req; // any instant stop source
  logic [NUM_AXES-1:0] decel_req; // any decel stop source
  logic [NUM_AXES-1:0] start_req; // drive or interpolation start

  // input high means the emergency loop is open
  // jumper picks polarity
  assign emg_act = EMERGENCY_OPEN_SEL_I ? EMERGENCY_STOP_INPUT_I : ~EMERGENCY_STOP_INPUT_I;

  // per-axis request decode and external stop qualification
  for (genvar g = 0; g < NUM_AXES; g++) begin : g_req
    // the qualifier costs up to its window of latency, which the stop allowance absorbs
    apst_filt #(
      .CYC(EXT_FILT_CYC)
    ) u_inst_filt (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .ce_i(CE_I),
      .raw_i(EXT_INST_STOP_I[g]),
      .lvl_o(ext_inst_f[g])
    );
    apst_filt #(
      .CYC(EXT_FILT_CYC)
    ) u_decel_filt (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .ce_i(CE_I),
      .raw_i(EXT_DECEL_STOP_I[g]),
      .lvl_o(ext_decel_f[g])
    );
    assign cmd_hit[g] = CMD_VALID_I && CMD_I.axes[g];
    assign inst_req[g] = (cmd_hit[g] && (CMD_I.code == CMD_STOP)) || emg_act ||
                         (ext_inst_f[g] && EXT_INST_EN_I[g]);
    assign decel_req[g] = (cmd_hit[g] && (CMD_I.code == CMD_DECEL)) ||
                          (ext_decel_f[g] && EXT_DECEL_EN_I[g]);
    assign start_req[g] = cmd_hit[g] && !inst_req[g] && (CMD_I.count != '0) &&
                          ((CMD_I.code == CMD_DRIVE) || (CMD_I.code == CMD_INTERP));
  end

  // next state of every axis, the host wait counter and the status capture
  always_comb begin
    q_next = q_reg;
    // host access window opens a fixed time after reset
    if (!q_reg.ready) begin
      q_next.wait_cnt = q_reg.wait_cnt + WAIT_W'(1);
      if (q_reg.wait_cnt == HOST_WAIT_CYC - WAIT_W'(1)) begin
        q_next.ready = 1'b1;
      end
    end
    q_next.stat.aux_zero = AUX_INPUT_ZERO_PAIR_I;
    q_next.stat.drv_fb = DRIVE_FEEDBACK_I;
    for (int a = 0; a < NUM_AXES; a++) begin
      if (AXIS_MODE_WR_EN_I && AXIS_MODE_WRITE_REG3_I.axes[a]) begin
        q_next.ax[a].hold_out = AXIS_MODE_WRITE_REG3_I.data[HOLD_OUTPUT_BIT_POS];
        q_next.ax[a].res_out = AXIS_MODE_WRITE_REG3_I.data[RESOLUTION_OUTPUT_BIT_POS];
      end
      case (q_reg.ax[a].state)
        ST_IDLE: begin
          q_next.ax[a].pulse = 1'b0;
          if (start_req[a]) begin
            // a start command to a busy axis is ignored, only idle axes start
            q_next.ax[a].state = ST_LEAD;
            q_next.ax[a].interp = (CMD_I.code == CMD_INTERP);
            q_next.ax[a].pdir = PULSE_DIR_MODE_I;
            q_next.ax[a].dir_pend = CMD_I.dirs[a];
            q_next.ax[a].remain = CMD_I.count;
            q_next.ax[a].emitted = '0;
            q_next.ax[a].elapsed = LEAD_W'(1);
            q_next.ax[a].period = (CMD_I.period < PERIOD_MIN) ? PERIOD_MIN : CMD_I.period;
            q_next.ax[a].half = q_next.ax[a].period >> 1;
            if (CMD_I.code == CMD_INTERP) begin
              q_next.ax[a].tgt = INTERP_PULSE_CYC;
              q_next.ax[a].dtgt = INTERP_PULSE_CYC - LEAD_W'(1);
            end else if (PULSE_DIR_MODE_I) begin
              q_next.ax[a].tgt = DIR_PULSE_CYC;
              q_next.ax[a].dtgt = DIR_VALID_CYC;
            end else begin
              q_next.ax[a].tgt = FIRST_PULSE_CYC;
              q_next.ax[a].dtgt = FIRST_PULSE_CYC - LEAD_W'(1);
            end
          end
        end
        ST_LEAD: begin
          if (inst_req[a]) begin
            // no pulse has left yet, so stop at once
            q_next.ax[a].state = ST_IDLE;
          end else begin
            if (decel_req[a] && (q_reg.ax[a].remain > DECEL_LEFT)) begin
              q_next.ax[a].remain = DECEL_LEFT;
            end
            q_next.ax[a].elapsed = q_reg.ax[a].elapsed + LEAD_W'(1);
            if (q_reg.ax[a].elapsed == q_reg.ax[a].dtgt - LEAD_W'(1)) begin
              q_next.ax[a].dir_out = q_reg.ax[a].dir_pend;
            end
            if (q_reg.ax[a].elapsed == q_reg.ax[a].tgt - LEAD_W'(1)) begin
              q_next.ax[a].state = ST_RUN;
              q_next.ax[a].pulse = 1'b1;
              q_next.ax[a].ph = q_reg.ax[a].period - PER_W'(1);
              q_next.ax[a].remain = q_next.ax[a].remain - CNT_W'(1);
              q_next.ax[a].emitted = q_reg.ax[a].emitted + CNT_W'(1);
            end
          end
        end
        ST_RUN: begin
          if (inst_req[a] && !q_reg.ax[a].pulse) begin
            q_next.ax[a].state = ST_IDLE;
          end else begin
            // a pulse already high is finished rather than cut short
            if (inst_req[a]) begin
              q_next.ax[a].remain = '0;
            end else if (decel_req[a] && (q_reg.ax[a].remain > DECEL_LEFT)) begin
              q_next.ax[a].remain = DECEL_LEFT;
            end
            if (q_reg.ax[a].ph == '0) begin
              if (q_next.ax[a].remain == '0) begin
                q_next.ax[a].state = ST_IDLE;
                q_next.ax[a].pulse = 1'b0;
              end else begin
                q_next.ax[a].pulse = 1'b1;
                q_next.ax[a].ph = q_reg.ax[a].period - PER_W'(1);
                q_next.ax[a].remain = q_next.ax[a].remain - CNT_W'(1);
                q_next.ax[a].emitted = q_reg.ax[a].emitted + CNT_W'(1);
              end
            end else begin
              // high for the upper half of the period, low for the rest
              q_next.ax[a].ph = q_reg.ax[a].ph - PER_W'(1);
              q_next.ax[a].pulse = (q_next.ax[a].ph >= q_reg.ax[a].half);
            end
          end
        end
        default: begin
          q_next.ax[a] = AXIS_RST;
        end
      endcase
      // pin mapping: pulse plus direction, or separate plus and minus pulses
      q_next.ax[a].p_out = q_next.ax[a].pdir ? q_next.ax[a].pulse :
                           (q_next.ax[a].pulse & ~q_next.ax[a].dir_out);
      q_next.ax[a].m_out = q_next.ax[a].pdir ? q_next.ax[a].dir_out :
                           (q_next.ax[a].pulse & q_next.ax[a].dir_out);
    end
  end

  // all sequencer state registers here; clock enable freezes everything
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      q_reg <= TOP_RST;
    end else if (CE_I) begin
      q_reg <= q_next;
    end
  end

  // host interrupt path
  apst_irq_latch u_irq (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .ce_i(CE_I),
    .int_n_i(MC_INT_N_I),
    .clr_i(IRQ_CLEAR_I),
    .status_rd_i(STATUS_READ_I),
    .irq_o(HOST_IRQ_O)
  );

  // outputs straight from flip-flops, except busy, which is decoded from the state register
  for (genvar g = 0; g < NUM_AXES; g++) begin : g_out
    assign DRIVE_PULSE_OUTPUTS_O[g] = q_reg.ax[g].p_out;
    assign DIRECTION_PULSE_OUTPUT_O[g] = q_reg.ax[g].m_out;
    assign HOLD_OFF_GENERAL_OUTPUT_O[g] = q_reg.ax[g].hold_out;
    assign STEP_RESOLUTION_GENERAL_OUTPUT_O[g] = q_reg.ax[g].res_out;
    assign BUSY_O[g] = (q_reg.ax[g].state != ST_IDLE);
    assign PULSE_CNT_O[g] = q_reg.ax[g].emitted;
  end
  assign INPUT_STATUS_READ_REGS_O = q_reg.stat;
  assign HOST_READY_O = q_reg.ready;

  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  for (genvar g = 0; g < NUM_AXES; g++) begin : g_chk
    sequence s_first_rise;
      (q_reg.ax[g].state == ST_RUN) && ($past(q_reg.ax[g].state) == ST_LEAD);
    endsequence
    sequence s_inst_busy;
      CE_I && inst_req[g] && (q_reg.ax[g].state != ST_IDLE);
    endsequence

    a_first_pulse_time: assert property (
      s_first_rise and (!q_reg.ax[g].interp && !q_reg.ax[g].pdir) |->
        q_reg.ax[g].elapsed == FIRST_PULSE_CYC)
      else $error("first pulse latency wrong");
    a_dir_valid_time: assert property (
      $changed(q_reg.ax[g].dir_out) && (q_reg.ax[g].state == ST_LEAD) &&
        q_reg.ax[g].pdir && !q_reg.ax[g].interp |-> q_reg.ax[g].elapsed == DIR_VALID_CYC)
      else $error("direction valid time wrong");
    a_dir_to_pulse: assert property (
      s_first_rise and (!q_reg.ax[g].interp && q_reg.ax[g].pdir) |->
        q_reg.ax[g].elapsed == DIR_PULSE_CYC)
      else $error("pulse after direction latency wrong");
    a_interp_first: assert property (
      s_first_rise and q_reg.ax[g].interp |-> q_reg.ax[g].elapsed == INTERP_PULSE_CYC)
      else $error("interpolation first pulse latency wrong");
    a_interp_dir_win: assert property (
      CE_I && $changed(q_reg.ax[g].dir_out) && q_reg.ax[g].interp |->
        ##[1:DIR_WIN] (q_reg.ax[g].pulse || q_reg.ax[g].state == ST_IDLE))
      else $error("interpolation direction far from pulse");
    a_inst_stop_one: assert property (
      s_inst_busy |=> (!$rose(q_reg.ax[g].pulse))[*8])
      else $error("pulse started after instant stop");
    a_decel_two_left: assert property (
      CE_I && decel_req[g] && !inst_req[g] && (q_reg.ax[g].state != ST_IDLE) |=>
        q_reg.ax[g].remain <= DECEL_LEFT)
      else $error("decel stop leaves too many pulses");
    a_emg_halt_axis: assert property (
      CE_I && emg_act && (q_reg.ax[g].state == ST_RUN) && !q_reg.ax[g].pulse |=>
        q_reg.ax[g].state == ST_IDLE)
      else $error("emergency stop did not halt axis");
    a_count_exact: assert property (
      $rose(q_reg.ax[g].pulse) |-> q_reg.ax[g].emitted == $past(q_reg.ax[g].emitted) + 1)
      else $error("pulse count does not match pulses");
    a_gp_follow_bits: assert property (
      CE_I && AXIS_MODE_WR_EN_I && AXIS_MODE_WRITE_REG3_I.axes[g] |=>
        HOLD_OFF_GENERAL_OUTPUT_O[g] == $past(AXIS_MODE_WRITE_REG3_I.data[HOLD_OUTPUT_BIT_POS]) &&
        STEP_RESOLUTION_GENERAL_OUTPUT_O[g] ==
          $past(AXIS_MODE_WRITE_REG3_I.data[RESOLUTION_OUTPUT_BIT_POS]))
      else $error("general outputs do not follow mode bits");
    a_gp_hold_level: assert property (
      CE_I && !(AXIS_MODE_WR_EN_I && AXIS_MODE_WRITE_REG3_I.axes[g]) |=>
        $stable(HOLD_OFF_GENERAL_OUTPUT_O[g]) && $stable(STEP_RESOLUTION_GENERAL_OUTPUT_O[g]))
      else $error("general outputs moved without a mode write");
    a_stop_low_idle: assert property (
      CE_I && inst_req[g] && (q_reg.ax[g].state == ST_RUN) && !q_reg.ax[g].pulse |=>
        q_reg.ax[g].state == ST_IDLE)
      else $error("stop between pulses did not halt axis");
  end

  a_status_follow_in: assert property (
    CE_I |=> INPUT_STATUS_READ_REGS_O == $past({AUX_INPUT_ZERO_PAIR_I, DRIVE_FEEDBACK_I}))
    else $error("input status does not follow inputs");
  a_ready_stays_up: assert property (
    HOST_READY_O |=> HOST_READY_O)
    else $error("host ready dropped after opening");
endmodule
